//--- inc/sps_pkg.sv
`default_nettype none
package sps_pkg;
   localparam logic [11:0] SPS_OFS_EVENT = 12'h000;
   localparam logic [11:0] SPS_OFS_MASK = 12'h004;
   localparam logic [11:0] SPS_OFS_STATE = 12'h008;
   localparam logic [11:0] SPS_OFS_FORCE = 12'h00C;
   localparam logic [11:0] SPS_OFS_CTRL = 12'h010;
   localparam logic [11:0] SPS_OFS_CARD = 12'h014;
   // socket state field positions
   localparam int SPS_B_SOCK_Y = 31;
   localparam int SPS_B_SOCK_X = 30;
   localparam int SPS_B_SOCK_3V3 = 29;
   localparam int SPS_B_SOCK_5V0 = 28;
   localparam int SPS_B_CARD_HI = 13;
   localparam int SPS_B_CARD_LO = 10;
   localparam int SPS_B_BADV = 9;
   localparam int SPS_B_LOSS = 8;
   localparam int SPS_B_UNREC = 7;
   localparam int SPS_B_IRQ = 6;
   localparam int SPS_B_WIDE = 5;
   localparam int SPS_B_NARROW = 4;
   localparam int SPS_B_PWR = 3;
   localparam int SPS_B_DET_B = 2;
   localparam int SPS_B_DET_A = 1;
   localparam int SPS_B_STS = 0;
   localparam int SPS_B_REINT = 14;
   // control register fields
   localparam int SPS_B_CTL_PWR = 0;
   localparam int SPS_B_CTL_BADV = 1;
   localparam int SPS_B_CTL_LOSS = 2;
   localparam int SPS_B_CTL_SOCK3 = 3;
   localparam int SPS_B_CTL_SOCK5 = 4;
   // detect bits match the idle-high pins, so no false event follows reset
   localparam logic [31:0] SPS_STATE_RST = 32'h3000_0006;
   localparam logic [3:0] SPS_EVENT_RST = 4'h0;
   localparam logic [3:0] SPS_MASK_RST = 4'h0;
   localparam logic [4:0] SPS_CTRL_RST = 5'h18;
   localparam int SPS_EV_W = 4;
   // interrogation hold time
   localparam int SPS_INTERROG_NS = 1000;
   localparam int SPS_CLK_PERIOD_NS = 5;
   localparam int SPS_INTERROG_CYC = SPS_INTERROG_NS / SPS_CLK_PERIOD_NS;
endpackage
`default_nettype wire

//--- rtl/sps_socket_state.sv
// Behaviour
// [RL1] read-only status word at 08h, 3000_00XXh reset
// [RL2] lvl y/x socket bits read zero
// [RL3] 3v3/5v0 socket bits one unless overridden
// [RL4] bits 27 to 14 read zero
// [RL5] card supply bits update only at interrogation end or force write
// [RL6] bit 9 flags invalid supply request
// [RL7] bit 8 flags removal data loss
// [RL8] bit 7 unrecognised card, held until valid card
// [RL9] bit 6 live card irq pin level
// [RL10] bits 5/4 card type, change at interrogation
// [RL11] bit 3 socket power state
// [RL12] bits 2/1 detect pins, frozen while interrogating
// [RL13] bit 0 live status-change pin level
// [RL14] force-event writes appear in status bits
// [RL15] bit changes set sticky events, write-one clears
// [RL16] force write loads card voltage/type bits
// [RL17] reinterrogate bit starts new interrogation; ignored here while one is already running
// [RL18] card pins synchronised before use
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sps_socket_state #(
   parameter int INTERROG_CYC = sps_pkg::SPS_INTERROG_CYC
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic i_card_irq_pin,
   input wire logic i_detect_a_pin,
   input wire logic i_detect_b_pin,
   input wire logic i_status_change_pin,
   input wire logic [3:0] i_card_supply_caps,
   input wire logic i_card_wide_bus,
   input wire logic i_card_narrow,
   input wire logic i_card_unknown,
   input wire logic i_cycle_pending,
   output logic o_irq,
   output logic [31:0] o_socket_state
);
   import sps_pkg::*;

   typedef enum logic [1:0] {
      SPS_IDLE = 2'b01,
      SPS_INTERROG = 2'b10
   } sps_state_e;

   localparam int CW = $clog2(INTERROG_CYC + 1);

   logic [2:0] sync_irq, sync_da, sync_db, sync_sts;
   logic [2:0] next_sync_irq, next_sync_da, next_sync_db, next_sync_sts;
   logic lvl_irq, lvl_da, lvl_db, lvl_sts;
   logic next_lvl_irq, next_lvl_da, next_lvl_db, next_lvl_sts;
   sps_state_e state, next_state;
   logic [CW-1:0] cnt, next_cnt;
   logic [31:0] stat, next_stat;
   logic [3:0] event_q, next_event;
   logic [3:0] mask_q, next_mask;
   logic [4:0] ctrl, next_ctrl;
   logic [31:0] rdata, next_rdata;
   logic ready, next_ready, slverr, next_slverr, irq, next_irq;
   logic wr;
   logic [3:0] chg;

   // write hit on a register held in byte lane 0
   function automatic logic low_wr(input logic w, input logic [11:0] a, input logic [11:0] ofs,
                                   input logic [3:0] st);
      low_wr = w && (a == ofs) && st[0];
   endfunction

   // new level counts once stages two and three agree
   function automatic logic filt(input logic [2:0] s, input logic cur);
      filt = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   // masked write helper honouring byte strobes
   function automatic logic [31:0] strb_mask(input logic [3:0] st);
      strb_mask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
   endfunction

   always_comb begin
      next_sync_irq = {sync_irq[1:0], i_card_irq_pin}; // RL18
      next_sync_da = {sync_da[1:0], i_detect_a_pin}; // RL18
      next_sync_db = {sync_db[1:0], i_detect_b_pin}; // RL18
      next_sync_sts = {sync_sts[1:0], i_status_change_pin}; // RL18
      next_lvl_irq = filt(sync_irq, lvl_irq);
      next_lvl_da = filt(sync_da, lvl_da);
      next_lvl_db = filt(sync_db, lvl_db);
      next_lvl_sts = filt(sync_sts, lvl_sts);
   end

   assign wr = i_psel && i_penable && i_pwrite && ready;

   logic [31:0] wmask, fdata;
   logic force_wr, insert, run_interrog;
   assign wmask = strb_mask(i_pstrb);
   assign fdata = i_pwdata & wmask;
   assign force_wr = wr && (i_paddr == SPS_OFS_FORCE);
   // insertion: both detects low after at least one was high
   assign insert = !next_lvl_da && !next_lvl_db && (lvl_da || lvl_db);
   assign run_interrog = insert || (force_wr && fdata[SPS_B_REINT]); // RL17

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      unique case (state)
         SPS_IDLE: begin
            if (run_interrog) begin
               next_state = SPS_INTERROG;
               next_cnt = CW'(INTERROG_CYC);
            end
         end
         SPS_INTERROG: begin
            if (cnt <= CW'(1)) begin
               next_state = SPS_IDLE;
               next_cnt = '0;
            end else begin
               next_cnt = cnt - CW'(1);
            end
         end
      endcase
   end

   logic done;
   assign done = (state == SPS_INTERROG) && (cnt <= CW'(1));

   always_comb begin
      next_ctrl = ctrl;
      if (low_wr(wr, i_paddr, SPS_OFS_CTRL, i_pstrb)) begin
         next_ctrl = i_pwdata[4:0];
      end
   end

   always_comb begin
      next_stat = stat;
      next_stat[SPS_B_SOCK_Y] = 1'b0; // RL2
      next_stat[SPS_B_SOCK_X] = 1'b0; // RL2
      next_stat[SPS_B_SOCK_3V3] = ctrl[SPS_B_CTL_SOCK3]; // RL3
      next_stat[SPS_B_SOCK_5V0] = ctrl[SPS_B_CTL_SOCK5]; // RL3
      next_stat[27:14] = '0; // RL4
      next_stat[SPS_B_BADV] = ctrl[SPS_B_CTL_BADV] | stat[SPS_B_BADV]; // RL6
      // loss on removal with a pending cycle
      if ((next_lvl_da || next_lvl_db) && !lvl_da && !lvl_db && i_cycle_pending) begin
         next_stat[SPS_B_LOSS] = 1'b1; // RL7
      end
      if (ctrl[SPS_B_CTL_LOSS]) begin
         next_stat[SPS_B_LOSS] = 1'b1; // RL7
      end
      if (done) begin
         next_stat[SPS_B_CARD_HI:SPS_B_CARD_LO] = i_card_supply_caps; // RL5
         next_stat[SPS_B_WIDE] = i_card_wide_bus; // RL10
         next_stat[SPS_B_NARROW] = i_card_narrow; // RL10
         if (i_card_unknown) begin
            next_stat[SPS_B_UNREC] = 1'b1; // RL8
         end else if (i_card_wide_bus || i_card_narrow) begin
            next_stat[SPS_B_UNREC] = 1'b0; // RL8
         end
      end
      next_stat[SPS_B_IRQ] = lvl_irq; // RL9
      next_stat[SPS_B_PWR] = ctrl[SPS_B_CTL_PWR]; // RL11
      if (state != SPS_INTERROG) begin
         next_stat[SPS_B_DET_B] = lvl_db; // RL12
         next_stat[SPS_B_DET_A] = lvl_da; // RL12
      end
      next_stat[SPS_B_STS] = lvl_sts; // RL13
      if (force_wr) begin
         next_stat[SPS_B_CARD_HI:SPS_B_CARD_LO] = fdata[SPS_B_CARD_HI:SPS_B_CARD_LO]; // RL16 RL14
         next_stat[SPS_B_BADV] = fdata[SPS_B_BADV]; // RL14
         next_stat[SPS_B_LOSS] = fdata[SPS_B_LOSS]; // RL14
         next_stat[SPS_B_UNREC] = fdata[SPS_B_UNREC]; // RL14
         next_stat[SPS_B_WIDE] = fdata[SPS_B_WIDE]; // RL16 RL14
         next_stat[SPS_B_NARROW] = fdata[SPS_B_NARROW]; // RL16 RL14
      end
   end

   assign chg = {next_stat[SPS_B_PWR] ^ stat[SPS_B_PWR], next_stat[SPS_B_DET_B] ^ stat[SPS_B_DET_B],
                 next_stat[SPS_B_DET_A] ^ stat[SPS_B_DET_A], next_stat[SPS_B_STS] ^ stat[SPS_B_STS]};

   always_comb begin
      next_event = event_q;
      if (low_wr(wr, i_paddr, SPS_OFS_EVENT, i_pstrb)) begin
         next_event = event_q & ~i_pwdata[SPS_EV_W-1:0]; // RL15
      end
      next_event = next_event | chg; // RL15
      if (force_wr) begin
         next_event = next_event | fdata[SPS_EV_W-1:0]; // RL14
      end
      next_mask = mask_q;
      if (low_wr(wr, i_paddr, SPS_OFS_MASK, i_pstrb)) begin
         next_mask = i_pwdata[SPS_EV_W-1:0];
      end
      next_irq = |(next_event & next_mask);
   end

   always_comb begin
      next_ready = 1'b0;
      next_rdata = rdata;
      next_slverr = 1'b0;
      if (i_psel && !ready) begin
         next_ready = 1'b1;
         unique case (i_paddr)
            SPS_OFS_EVENT: next_rdata = {28'h0, event_q};
            SPS_OFS_MASK: next_rdata = {28'h0, mask_q};
            SPS_OFS_STATE: next_rdata = stat; // RL1
            SPS_OFS_FORCE: next_rdata = 32'h0;
            SPS_OFS_CTRL: next_rdata = {27'h0, ctrl};
            SPS_OFS_CARD: next_rdata = {31'h0, state == SPS_INTERROG};
            default: begin
               next_rdata = 32'h0;
               next_slverr = 1'b1;
            end
         endcase
      end
      if (!i_psel) begin
         next_rdata = 32'h0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         sync_irq <= 3'h0;
         sync_da <= 3'h7;
         sync_db <= 3'h7;
         sync_sts <= 3'h0;
         lvl_irq <= 1'b0;
         lvl_da <= 1'b1;
         lvl_db <= 1'b1;
         lvl_sts <= 1'b0;
         state <= SPS_IDLE;
         cnt <= '0;
         stat <= SPS_STATE_RST; // RL1
         event_q <= SPS_EVENT_RST;
         mask_q <= SPS_MASK_RST;
         ctrl <= SPS_CTRL_RST;
         rdata <= 32'h0;
         ready <= 1'b0;
         slverr <= 1'b0;
         irq <= 1'b0;
      end else begin
         sync_irq <= next_sync_irq;
         sync_da <= next_sync_da;
         sync_db <= next_sync_db;
         sync_sts <= next_sync_sts;
         lvl_irq <= next_lvl_irq;
         lvl_da <= next_lvl_da;
         lvl_db <= next_lvl_db;
         lvl_sts <= next_lvl_sts;
         state <= next_state;
         cnt <= next_cnt;
         stat <= next_stat;
         event_q <= next_event;
         mask_q <= next_mask;
         ctrl <= next_ctrl;
         rdata <= next_rdata;
         ready <= next_ready;
         slverr <= next_slverr;
         irq <= next_irq;
      end
   end

   assign o_pready = ready;
   assign o_prdata = rdata;
   assign o_pslverr = slverr;
   assign o_irq = irq;
   assign o_socket_state = stat;
endmodule
`default_nettype wire

//--- verif/sps_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module sps_card_model (
   input wire logic i_mclk,
   input wire logic i_insert,
   input wire logic [1:0] i_kind,
   input wire logic [3:0] i_caps,
   input wire logic [3:0] i_lag,
   output logic o_det_a,
   output logic o_det_b,
   output logic o_wide,
   output logic o_narrow,
   output logic o_unknown,
   output logic [3:0] o_caps
);
   logic [3:0] cnt;
   // second detect contact lands i_lag cycles after the first
   always_ff @(posedge i_mclk) begin
      cnt <= !i_insert ? 4'h0 : (cnt == i_lag ? cnt : cnt + 4'h1);
   end
   assign o_det_a = !i_insert;
   assign o_det_b = !(i_insert && cnt == i_lag);
   // removed card leaves floating lines: show inverted values
   assign o_caps = i_insert ? i_caps : ~i_caps;
   assign o_wide = i_insert && i_kind == 2'h1;
   assign o_narrow = i_insert && i_kind == 2'h2;
   assign o_unknown = i_insert && i_kind == 2'h3;
endmodule
`default_nettype wire

//--- verif/sps_socket_state_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sps_socket_state_checker
   import sps_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic i_card_irq_pin,
   input wire logic i_status_change_pin,
   input wire logic [31:0] o_socket_state
);
   logic wr_ctrl;
   logic [4:0] ctrl_last;
   assign wr_ctrl = i_psel && i_penable && o_pready && i_pwrite && i_paddr == SPS_OFS_CTRL;
   always_ff @(posedge i_mclk) begin
      if (wr_ctrl) begin
         ctrl_last <= i_pwdata[4:0];
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   chk_lvl_zero: assert property (o_socket_state[31:30] == 2'h0)
      else $error("level bits set");
   chk_resv_zero: assert property (o_socket_state[27:14] == 14'h0)
      else $error("reserved bits set");
   chk_ready_wait: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
      else $error("ready timing wrong");
   chk_irq_live: assert property (i_card_irq_pin [*6] |-> o_socket_state[6])
      else $error("irq level not shown");
   chk_irq_sync: assert property (!i_card_irq_pin [*6] ##1 i_card_irq_pin |=> !o_socket_state[6])
      else $error("irq pin not synchronised");
   chk_sts_live: assert property (!i_status_change_pin [*6] |-> !o_socket_state[0])
      else $error("status pin level wrong");
   chk_power_bit: assert property (wr_ctrl |-> ##2 o_socket_state[3] == ctrl_last[0])
      else $error("power bit wrong");
   chk_sock_caps: assert property (wr_ctrl |-> ##2 o_socket_state[29:28] == {ctrl_last[3], ctrl_last[4]})
      else $error("socket supply bits wrong");
endmodule
bind sps_socket_state sps_socket_state_checker u_chk (.i_mclk, .i_rstn, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_pready, .i_card_irq_pin, .i_status_change_pin, .o_socket_state);
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sps_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, irq_pin = 0, sts_pin = 0, pend = 0, ins = 0, err;
   logic pready, pslverr, irq, deta, detb, wide, narrow, unk;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q, sstate;
   logic [1:0] kind = 2'h0;
   logic [3:0] caps = 4'h0, lag = 4'h0, ccaps;
   int mismatches = 0, checks = 0;
   always #2.5 clk = ~clk;
   sps_socket_state #(.INTERROG_CYC(40)) DUT (.i_mclk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .i_card_irq_pin(irq_pin), .i_detect_a_pin(deta), .i_detect_b_pin(detb),
      .i_status_change_pin(sts_pin), .i_card_supply_caps(ccaps), .i_card_wide_bus(wide), .i_card_narrow(narrow),
      .i_card_unknown(unk), .i_cycle_pending(pend), .o_irq(irq), .o_socket_state(sstate));
   sps_card_model u_card (.i_mclk(clk), .i_insert(ins), .i_kind(kind), .i_caps(caps), .i_lag(lag),
      .o_det_a(deta), .o_det_b(detb), .o_wide(wide), .o_narrow(narrow), .o_unknown(unk), .o_caps(ccaps));
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp("read", e, q);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic summarize;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      w(5000);
      mismatches++;
      summarize();
   end
   initial begin
      w(5);
      rstn <= 1;
      w(10);
      rd(SPS_OFS_STATE, 32'h3000_0006);
      cmp("socket_state", 32'h3000_0006, sstate);
      wr(SPS_OFS_STATE, 32'hFFFF_FFFF);
      rd(SPS_OFS_STATE, 32'h3000_0006);
      rd(12'h020, 32'h0);
      cmp("slverr", 32'h1, {31'h0, err});
      rd(SPS_OFS_EVENT, 32'h0);
      wr(SPS_OFS_MASK, 32'hF);
      rd(SPS_OFS_MASK, 32'hF);
      irq_pin <= 1;
      sts_pin <= 1;
      w(10);
      rd(SPS_OFS_STATE, 32'h3000_0047);
      cmp("irq", 32'h1, {31'h0, irq});
      rd(SPS_OFS_EVENT, 32'h1);
      wr(SPS_OFS_EVENT, 32'hF);
      rd(SPS_OFS_EVENT, 32'h0);
      cmp("irq", 32'h0, {31'h0, irq});
      wr(SPS_OFS_MASK, 32'h0);
      wr(SPS_OFS_FORCE, 32'h8);
      w(2);
      cmp("irq", 32'h0, {31'h0, irq});
      wr(SPS_OFS_MASK, 32'hF);
      w(2);
      cmp("irq", 32'h1, {31'h0, irq});
      rd(SPS_OFS_EVENT, 32'h8);
      rd(SPS_OFS_FORCE, 32'h0);
      wr(SPS_OFS_EVENT, 32'hF);
      kind <= 2'h1;
      caps <= 4'h3;
      lag <= 4'h5;
      ins <= 1;
      w(60);
      rd(SPS_OFS_STATE, 32'h3000_0C61);
      rd(SPS_OFS_EVENT, 32'h6);
      wr(SPS_OFS_EVENT, 32'hF);
      caps <= 4'hF;
      w(10);
      rd(SPS_OFS_STATE, 32'h3000_0C61);
      wr(SPS_OFS_CTRL, 32'h1);
      rd(SPS_OFS_STATE, 32'h0000_0C69);
      wr(SPS_OFS_CTRL, 32'h1A);
      rd(SPS_OFS_STATE, 32'h3000_0E61);
      wr(SPS_OFS_CTRL, 32'h18);
      rd(SPS_OFS_CTRL, 32'h18);
      wr(SPS_OFS_FORCE, 32'h4000);
      w(60);
      rd(SPS_OFS_STATE, 32'h3000_3C61);
      wr(SPS_OFS_FORCE, 32'h2190);
      rd(SPS_OFS_STATE, 32'h3000_21D1);
      wr(SPS_OFS_FORCE, 32'h0);
      pend <= 1;
      ins <= 0;
      w(10);
      rd(SPS_OFS_STATE, 32'h3000_0147);
      wr(SPS_OFS_FORCE, 32'h0);
      pend <= 0;
      kind <= 2'h3;
      caps <= 4'h2;
      lag <= 4'h0;
      ins <= 1;
      w(10);
      rd(SPS_OFS_STATE, 32'h3000_0047);
      rd(SPS_OFS_CARD, 32'h1);
      w(40);
      rd(SPS_OFS_STATE, 32'h3000_08C1);
      ins <= 0;
      w(10);
      kind <= 2'h2;
      caps <= 4'h1;
      ins <= 1;
      w(60);
      rd(SPS_OFS_STATE, 32'h3000_0451);
      cmp("socket_state", 32'h3000_0451, sstate);
      summarize();
   end
endmodule
`default_nettype wire
